// *** logic/liems_route.sv ***
// route registers and steering of the shared PCI lines onto controller inputs
`include "liems_defs.svh"
module liems_route #(
    parameter int LINES = 8
) (
    input  wire logic              clk_sys_i,
    input  wire logic              srst_i,
    input  wire logic              cfg_wr_i,
    input  wire logic [7:0]        cfg_addr_i,
    input  wire logic [3:0]        cfg_be_i,
    input  wire logic [31:0]       cfg_wdata_i,
    output      logic [31:0]       cfg_rdata_o,
    input  wire logic [LINES-1:0]  pirq_n_i,
    liems_steer_if.src             st
);
    logic [31:0] route [2];
    logic [31:0] next_route [2];
    logic [31:0] next_rdata;

    function automatic logic [15:0] dest_of(input logic [7:0] r);
        logic [15:0] d;
        d = 16'h0001 << r[3:0];
        if (r[`LIEMS_ROUTE_DIS_BIT])
            d = 16'h0000;
        return d & `LIEMS_VALID_DEST;
    endfunction

    always_comb
    begin
        next_route[0] = route[0];
        next_route[1] = route[1];
        for (int b = 0; b < 4; b++)
        begin
            if (cfg_wr_i && cfg_be_i[b] && cfg_addr_i == `LIEMS_ROUTE_LO_OFS)
                next_route[0][b*8 +: 8] = cfg_wdata_i[b*8 +: 8];
            if (cfg_wr_i && cfg_be_i[b] && cfg_addr_i == `LIEMS_ROUTE_HI_OFS)
                next_route[1][b*8 +: 8] = cfg_wdata_i[b*8 +: 8];
        end
        case (cfg_addr_i)
            `LIEMS_ROUTE_LO_OFS: next_rdata = route[0];
            `LIEMS_ROUTE_HI_OFS: next_rdata = route[1];
            default:             next_rdata = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            route[0]    <= `LIEMS_ROUTE_RST;
            route[1]    <= `LIEMS_ROUTE_RST;
            cfg_rdata_o <= 32'h00000000;
        end
        else
        begin
            route[0]    <= next_route[0];
            route[1]    <= next_route[1];
            cfg_rdata_o <= next_rdata;
        end
    end

    // lines sharing one input are or-ed; each line is inverted to active high
    always_comb
    begin
        st.pci_level = 16'h0000;
        st.pci_dest  = 16'h0000;
        for (int i = 0; i < LINES; i++)
        begin
            st.pci_dest  = st.pci_dest | dest_of(route[i/4][(i%4)*8 +: 8]);
            st.pci_level = st.pci_level
                         | (dest_of(route[i/4][(i%4)*8 +: 8]) & {16{~pirq_n_i[i]}});
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    AST_DEST_LEGAL: assert property ((st.pci_dest & ~`LIEMS_VALID_DEST) == 16'h0000)
        else $error("PCI line steered to an illegal input");
    AST_ROUTE_RESET: assert property (disable iff (1'b0)
        $past(srst_i) |-> route[0] == `LIEMS_ROUTE_RST && route[1] == `LIEMS_ROUTE_RST)
        else $error("route registers not at reset value");
    AST_INVERT: assert property ((&pirq_n_i) |-> st.pci_level == 16'h0000)
        else $error("idle PCI lines raised an input");
    AST_DISABLE: assert property ((&{route[0][7], route[0][15], route[0][23], route[0][31],
        route[1][7], route[1][15], route[1][23], route[1][31]}) |-> st.pci_dest == 16'h0000)
        else $error("disabled route still drives an input");
endmodule

// *** logic/liems_top.sv ***
// cascaded legacy interrupt controller pair: completion, masking, PCI steering
`include "liems_defs.svh"
module liems_top #(
    parameter int LINES       = 8,
    parameter int PM_LINE     = 0,
    parameter int HEALTH_LINE = 0
) (
    input  wire logic              clk_sys_i,
    input  wire logic              srst_i,
    input  wire logic              cfg_wr_i,
    input  wire logic [7:0]        cfg_addr_i,
    input  wire logic [3:0]        cfg_be_i,
    input  wire logic [31:0]       cfg_wdata_i,
    output      logic [31:0]       cfg_rdata_o,
    input  wire logic              host_wr_i,
    input  wire logic              host_sec_i,
    input  wire logic              host_a0_i,
    input  wire logic [7:0]        host_wdata_i,
    output      logic [7:0]        host_rdata_o,
    input  wire logic              interrupt_ack_strobe_n_i,
    output      logic              intr_o,
    output      logic [3:0]        ack_level_o,
    input  wire logic              auto_completion_mode_i,
    input  wire logic [15:0]       edge_level_select_i,
    input  wire logic [15:0]       legacy_irq_i,
    input  wire logic [LINES-1:0]  shared_pci_irq_lines_n_i,
    output      logic [LINES-1:0]  shared_pci_irq_lines_o,
    output      logic [LINES-1:0]  shared_pci_irq_lines_oe_o,
    input  wire logic              power_mgmt_event_i,
    input  wire logic              system_health_event_i
);
    liems_steer_if st ();

    liems_route #(
        .LINES (LINES)
    ) i_liems_route (
        .clk_sys_i   (clk_sys_i),
        .srst_i      (srst_i),
        .cfg_wr_i    (cfg_wr_i),
        .cfg_addr_i  (cfg_addr_i),
        .cfg_be_i    (cfg_be_i),
        .cfg_wdata_i (cfg_wdata_i),
        .cfg_rdata_o (cfg_rdata_o),
        .pirq_n_i    (shared_pci_irq_lines_n_i),
        .st          (st.src)
    );

    logic [7:0]           in_service_bits      [2];
    logic [7:0]           channel_mask_register      [2];
    logic [7:0]           irr      [2];
    logic [7:0]           prev_in  [2];
    logic                 special_mask_select      [2];
    logic [7:0]           next_isr [2];
    logic [7:0]           next_imr [2];
    logic [7:0]           next_irr [2];
    logic                 next_smm [2];
    logic [7:0]           set_b    [2];
    logic [7:0]           clr_b    [2];
    logic [7:0]           ctl_in   [2];
    logic [7:0]           edge_level_select     [2];
    logic [7:0]           req      [2];
    logic [3:0]           win      [2];
    logic [15:0]          merged;
    logic                 strobe_q;
    logic                 ack_fall;
    logic                 ack_rise;
    liems_pkg::liems_ack_t ack_st;
    liems_pkg::liems_ack_t next_ack_st;
    logic [3:0]           next_ack_level;
    logic [7:0]           next_rdata;
    logic [LINES-1:0]     next_oe;

    // {found, index}; index 0 is the highest priority
    function automatic logic [3:0] top_bit(input logic [7:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--)
        begin
            if (v[i])
                r = {1'b1, 3'(i)};
        end
        return r;
    endfunction

    function automatic logic [7:0] one_hot(input logic [2:0] i);
        return 8'h01 << i;
    endfunction

    // winning request, honouring nesting or special mask mode
    function automatic logic [3:0] pick(input logic [7:0] rq, input logic [7:0] sv,
                                        input logic sm);
        logic [3:0] t;
        logic [3:0] h;
        t = top_bit(rq);
        h = top_bit(sv);
        if (sm)
            t = top_bit(rq & ~sv);
        else if (h[3] && t[2:0] >= h[2:0])
            t = 4'h0;
        return t;
    endfunction

    // in-service bit cleared by a non-specific completion
    function automatic logic [7:0] ns_clear(input logic [7:0] sv, input logic [7:0] mk,
                                            input logic sm);
        logic [3:0] t;
        t = top_bit(sm ? (sv & ~mk) : sv);
        return t[3] ? one_hot(t[2:0]) : 8'h00;
    endfunction

    // a PCI destination no longer takes serial legacy sources
    assign merged = (legacy_irq_i & ~st.pci_dest) | st.pci_level;

    assign edge_level_select[1]   = edge_level_select_i[15:8];
    assign edge_level_select[0]   = edge_level_select_i[7:0] | one_hot(3'(`LIEMS_CASCADE_IN));
    assign req[0]    = irr[0] & ~channel_mask_register[0];
    assign req[1]    = irr[1] & ~channel_mask_register[1];
    assign win[0]    = pick(req[0], in_service_bits[0], special_mask_select[0]);
    assign win[1]    = pick(req[1], in_service_bits[1], special_mask_select[1]);
    assign intr_o    = win[0][3];
    assign ack_fall  = strobe_q & ~interrupt_ack_strobe_n_i;
    assign ack_rise  = ~strobe_q & interrupt_ack_strobe_n_i;
    assign shared_pci_irq_lines_o = '0;

    always_comb
    begin
        ctl_in[1] = merged[15:8];
        ctl_in[0] = merged[7:0];
        ctl_in[0][`LIEMS_CASCADE_IN] = win[1][3];
    end

    always_comb
    begin
        next_ack_st    = ack_st;
        next_ack_level = ack_level_o;
        for (int c = 0; c < 2; c++)
        begin
            set_b[c]    = 8'h00;
            clr_b[c]    = 8'h00;
            next_imr[c] = channel_mask_register[c];
            next_smm[c] = special_mask_select[c];
            next_irr[c] = (edge_level_select[c] & ctl_in[c])
                        | (~edge_level_select[c] & (irr[c] | (ctl_in[c] & ~prev_in[c])));
            if (host_wr_i && host_sec_i == (c == 1))
            begin
                if (host_a0_i)
                    next_imr[c] = host_wdata_i;
                else if (host_wdata_i[4:3] == `LIEMS_SEL_OCW2)
                begin
                    if (host_wdata_i[7:5] == `LIEMS_CMD_NS_EOI)
                        clr_b[c] = ns_clear(in_service_bits[c], channel_mask_register[c], special_mask_select[c]);
                    else if (host_wdata_i[7:5] == `LIEMS_CMD_SP_EOI)
                        clr_b[c] = one_hot(host_wdata_i[2:0]);
                end
                else if (host_wdata_i[4:3] == `LIEMS_SEL_MODE_COMMAND_WORD)
                begin
                    if (host_wdata_i[`LIEMS_SPECIAL_MASK_WRITE_ENABLE_BIT])
                        next_smm[c] = host_wdata_i[`LIEMS_SMM_BIT];
                end
            end
        end
        case (ack_st)
            liems_pkg::ACK_IDLE:
            begin
                if (ack_fall)
                begin
                    next_ack_st    = liems_pkg::ACK_FIRST;
                    next_ack_level = {1'b0, `LIEMS_DEFAULT_LVL};
                    if (win[0][3])
                    begin
                        set_b[0]       = one_hot(win[0][2:0]);
                        next_ack_level = {1'b0, win[0][2:0]};
                        if (win[0][2:0] == 3'(`LIEMS_CASCADE_IN))
                        begin
                            next_ack_level = {1'b1, `LIEMS_DEFAULT_LVL};
                            if (win[1][3])
                            begin
                                set_b[1]       = one_hot(win[1][2:0]);
                                next_ack_level = {1'b1, win[1][2:0]};
                            end
                        end
                    end
                end
            end
            liems_pkg::ACK_FIRST:
            begin
                if (ack_rise)
                    next_ack_st = liems_pkg::ACK_GAP;
            end
            liems_pkg::ACK_GAP:
            begin
                if (ack_fall)
                    next_ack_st = liems_pkg::ACK_SECOND;
            end
            liems_pkg::ACK_SECOND:
            begin
                if (ack_rise)
                begin
                    next_ack_st = liems_pkg::ACK_IDLE;
                    // only the primary completes itself; secondary never does
                    if (auto_completion_mode_i)
                        clr_b[0] = clr_b[0] | ns_clear(in_service_bits[0], channel_mask_register[0], special_mask_select[0]);
                end
            end
            default:
                next_ack_st = liems_pkg::ACK_IDLE;
        endcase
        for (int c = 0; c < 2; c++)
        begin
            // a set in the same cycle as a clear wins
            next_isr[c] = (in_service_bits[c] & ~clr_b[c]) | set_b[c];
            next_irr[c] = next_irr[c] & ~(set_b[c] & ~edge_level_select[c]);
        end
        next_rdata = host_a0_i ? channel_mask_register[host_sec_i] : in_service_bits[host_sec_i];
        next_oe    = '0;
        if (power_mgmt_event_i)
            next_oe[PM_LINE] = 1'b1;
        if (system_health_event_i)
            next_oe[HEALTH_LINE] = 1'b1;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (srst_i)
        begin
            for (int c = 0; c < 2; c++)
            begin
                in_service_bits[c]     <= 8'h00;
                channel_mask_register[c]     <= 8'h00;
                irr[c]     <= 8'h00;
                prev_in[c] <= 8'h00;
                special_mask_select[c]     <= 1'b0;
            end
            ack_st                    <= liems_pkg::ACK_IDLE;
            ack_level_o               <= 4'h0;
            strobe_q                  <= 1'b1;
            host_rdata_o              <= 8'h00;
            shared_pci_irq_lines_oe_o <= '0;
        end
        else
        begin
            for (int c = 0; c < 2; c++)
            begin
                in_service_bits[c]     <= next_isr[c];
                channel_mask_register[c]     <= next_imr[c];
                irr[c]     <= next_irr[c];
                prev_in[c] <= ctl_in[c];
                special_mask_select[c]     <= next_smm[c];
            end
            ack_st                    <= next_ack_st;
            ack_level_o               <= next_ack_level;
            strobe_q                  <= interrupt_ack_strobe_n_i;
            host_rdata_o              <= next_rdata;
            shared_pci_irq_lines_oe_o <= next_oe;
        end
    end

    // helpers read only by the checks below
    logic       pri_ns_wr;
    logic       pri_sp_wr;
    logic       pri_mode_command_word_wr;
    logic [3:0] hi_isr0;
    assign pri_ns_wr   = host_wr_i && !host_sec_i && !host_a0_i
                       && host_wdata_i[4:3] == `LIEMS_SEL_OCW2
                       && host_wdata_i[7:5] == `LIEMS_CMD_NS_EOI;
    assign pri_sp_wr   = host_wr_i && !host_sec_i && !host_a0_i
                       && host_wdata_i[4:3] == `LIEMS_SEL_OCW2
                       && host_wdata_i[7:5] == `LIEMS_CMD_SP_EOI;
    assign pri_mode_command_word_wr = host_wr_i && !host_sec_i && !host_a0_i
                       && host_wdata_i[4:3] == `LIEMS_SEL_MODE_COMMAND_WORD;
    assign hi_isr0     = top_bit(in_service_bits[0]);

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);

    AST_NS_TOP: assert property (pri_ns_wr && !special_mask_select[0] && hi_isr0[3] && set_b[0] == 8'h00
        |=> !in_service_bits[0][$past(hi_isr0[2:0])])
        else $error("non-specific completion missed the top in-service bit");
    AST_SP_NAMED: assert property (pri_sp_wr && set_b[0] == 8'h00
        |=> !in_service_bits[0][$past(host_wdata_i[2:0])])
        else $error("specific completion left the named bit set");
    AST_SMM_SKIP: assert property (pri_ns_wr && special_mask_select[0]
        |=> (in_service_bits[0] & $past(in_service_bits[0] & channel_mask_register[0])) == $past(in_service_bits[0] & channel_mask_register[0]))
        else $error("masked in-service bit cleared in special mask mode");
    AST_AUTO_DONE: assert property (ack_st == liems_pkg::ACK_SECOND && ack_rise
        && auto_completion_mode_i && !host_wr_i && hi_isr0[3]
        |=> $countones(in_service_bits[0]) == $countones($past(in_service_bits[0])) - 1)
        else $error("automatic completion did not clear one bit");
    AST_SEC_KEEPS: assert property (ack_st == liems_pkg::ACK_SECOND && ack_rise && !host_wr_i
        |=> in_service_bits[1] == $past(in_service_bits[1]))
        else $error("secondary completed without a command");
    AST_MASK_LOAD: assert property (host_wr_i && !host_sec_i && host_a0_i
        |=> channel_mask_register[0] == $past(host_wdata_i))
        else $error("mask word not loaded");
    AST_CASCADE_MASK: assert property (channel_mask_register[0][`LIEMS_CASCADE_IN] && ack_fall
        && ack_st == liems_pkg::ACK_IDLE |=> !ack_level_o[3] && in_service_bits[1] == $past(in_service_bits[1]))
        else $error("secondary served while cascade masked");
    AST_SMM_ELIG: assert property (special_mask_select[0] && (req[0] & ~in_service_bits[0]) != 8'h00 |-> intr_o)
        else $error("unmasked request ignored in special mask mode");
    AST_SMM_LOAD: assert property (pri_mode_command_word_wr && host_wdata_i[`LIEMS_SPECIAL_MASK_WRITE_ENABLE_BIT]
        |=> special_mask_select[0] == $past(host_wdata_i[`LIEMS_SMM_BIT]))
        else $error("special mask mode not loaded");
    AST_NEST_TOP: assert property (!special_mask_select[0] && in_service_bits[0][0] |-> !intr_o)
        else $error("request raised under top level in service");
    AST_LEGACY_GATE: assert property (st.pci_dest[3] |-> merged[3] == st.pci_level[3])
        else $error("legacy source reached a PCI destination");
    AST_EVENT_DRIVE: assert property (power_mgmt_event_i |=> shared_pci_irq_lines_oe_o[PM_LINE])
        else $error("power event did not assert its line");
    AST_EDGE_ONCE: assert property (!edge_level_select[1][0] && irr[1][0] && !ctl_in[1][0] && set_b[1][0]
        |=> !irr[1][0])
        else $error("edge request not consumed by acknowledge");

    COV_ACK_DONE: cover property (ack_st == liems_pkg::ACK_SECOND && ack_rise);
    COV_CASCADE: cover property (ack_st == liems_pkg::ACK_FIRST && ack_level_o[3]);
    COV_SMM_ON: cover property (pri_mode_command_word_wr ##1 special_mask_select[0]);
    COV_NS_EOI: cover property (pri_ns_wr && hi_isr0[3]);
endmodule

// *** pkg/liems_defs.svh ***
// offsets, field positions and reset values of the interrupt steering block
// Functional notes
// - non-specific completion clears highest set in-service bit
// - specific completion clears the named in-service bit
// - special mask mode: completion skips masked bits
// - auto completion at trailing edge of last ack
// - auto completion only on primary controller
// - eight-bit channel mask written by mask word
// - primary cascade mask blocks all secondary requests
// - special mask: every unmasked request not already in service is eligible
// - mode word loads special mask when enabled
// - PCI lines route to inputs 3-7,9-12,14,15
// - route registers at config offsets 60h, 68h
// - several PCI lines may share one input
// - active-low PCI lines inverted to high level
// - PCI destination input refuses serial legacy sources
// - internal events assert a shared PCI line
// - level select: high level or rising edge
// - in-service level holds off equal and lower
`ifndef LIEMS_DEFS_SVH
`define LIEMS_DEFS_SVH
`define LIEMS_ROUTE_LO_OFS  8'h60
`define LIEMS_ROUTE_HI_OFS  8'h68
`define LIEMS_ROUTE_RST     32'h80808080
`define LIEMS_ROUTE_DIS_BIT 7
`define LIEMS_VALID_DEST    16'hDEF8
`define LIEMS_CASCADE_IN    2
`define LIEMS_DEFAULT_LVL   3'h7
`define LIEMS_CMD_NS_EOI    3'h1
`define LIEMS_CMD_SP_EOI    3'h3
`define LIEMS_SEL_OCW2      2'h0
`define LIEMS_SEL_MODE_COMMAND_WORD      2'h1
`define LIEMS_SPECIAL_MASK_WRITE_ENABLE_BIT      6
`define LIEMS_SMM_BIT       5
`endif

// *** pkg/liems_pkg.sv ***
// types of the interrupt steering block
package liems_pkg;
    typedef enum logic [3:0] {
        ACK_IDLE   = 4'h1,
        ACK_FIRST  = 4'h2,
        ACK_GAP    = 4'h4,
        ACK_SECOND = 4'h8
    } liems_ack_t;
    typedef logic [15:0] liems_irq_vec_t;
endpackage

// *** pkg/liems_steer_if.sv ***
// steered PCI levels passed from the route block to the controllers
interface liems_steer_if;
    liems_pkg::liems_irq_vec_t pci_level;
    liems_pkg::liems_irq_vec_t pci_dest;
    modport src (output pci_level, output pci_dest);
    modport dst (input pci_level, input pci_dest);
endinterface

// *** tb/legacy_irq_eoi_mask_steering_test.sv ***
// self-checking bench of the interrupt controller pair and PCI steering
module legacy_irq_eoi_mask_steering_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_sys_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        cfg_wr = 1'b0;
    logic [7:0]  cfg_addr = 8'h00;
    logic [3:0]  cfg_be = 4'h0;
    logic [31:0] cfg_wdata = 32'h0;
    logic [31:0] cfg_rdata;
    logic        host_wr, host_sec, host_a0, ack_n, intr, auto_completion_mode = 1'b0;
    logic [7:0]  host_wdata, host_rdata;
    logic [3:0]  ack_level;
    logic [15:0] edge_level_select = 16'hFFFF;
    logic [15:0] legacy = 16'h0000;
    logic [7:0]  ext_n = 8'hFF;
    logic [7:0]  pci_o, pci_oe;
    logic        pm = 1'b0;
    logic        health = 1'b0;
    int          fail_count = 0;
    int          n_tests = 0;
    int          cyc = 0;
    wire  [7:0]  pci_n = ext_n & ~pci_oe;
    initial
    begin
        forever #2 clk_sys_i = ~clk_sys_i;
    end
    liems_host_model i_liems_host_model (.clk_sys_i(clk_sys_i), .host_wr_o(host_wr),
        .host_sec_o(host_sec), .host_a0_o(host_a0), .host_wdata_o(host_wdata), .ack_n_o(ack_n));
    liems_top #(.LINES(8), .PM_LINE(0), .HEALTH_LINE(3)) i_liems_top (.clk_sys_i(clk_sys_i),
        .srst_i(srst_i), .cfg_wr_i(cfg_wr), .cfg_addr_i(cfg_addr), .cfg_be_i(cfg_be),
        .cfg_wdata_i(cfg_wdata), .cfg_rdata_o(cfg_rdata), .host_wr_i(host_wr),
        .host_sec_i(host_sec), .host_a0_i(host_a0), .host_wdata_i(host_wdata),
        .host_rdata_o(host_rdata), .interrupt_ack_strobe_n_i(ack_n), .intr_o(intr),
        .ack_level_o(ack_level), .auto_completion_mode_i(auto_completion_mode), .edge_level_select_i(edge_level_select),
        .legacy_irq_i(legacy), .shared_pci_irq_lines_n_i(pci_n), .shared_pci_irq_lines_o(pci_o),
        .shared_pci_irq_lines_oe_o(pci_oe), .power_mgmt_event_i(pm),
        .system_health_event_i(health));
    task automatic summarize();
        if (fail_count == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            $display("Error %0t: got %0h expected %0h", $time, got, exp);
            fail_count++;
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic cfg_write(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk_sys_i);
        cfg_wr <= 1'b1;
        cfg_addr <= a;
        cfg_be <= be;
        cfg_wdata <= d;
        @(posedge clk_sys_i);
        cfg_wr <= 1'b0;
    endtask
    task automatic cfg_read(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys_i);
        cfg_addr <= a;
        wt(2);
        chk(cfg_rdata, exp);
    endtask
    task automatic t_reset();
        cfg_read(8'h60, 32'h80808080);
        cfg_read(8'h68, 32'h80808080);
        cfg_read(8'h64, 32'h00000000);
    endtask
    task automatic t_steer();
        cfg_write(8'h60, 4'h1, 32'h0000000A);
        cfg_write(8'h60, 4'h2, 32'h00000A00);
        cfg_read(8'h60, 32'h80800A0A);
        ext_n[0] <= 1'b0;
        wt(3);
        chk(32'(intr), 32'h1);
        i_liems_host_model.ack();
        chk(32'(ack_level), 32'hA);
        ext_n <= 8'hFD;
        i_liems_host_model.eoi_both();
        wt(3);
        chk(32'(intr), 32'h1);
        i_liems_host_model.ack();
        chk(32'(ack_level), 32'hA);
        ext_n <= 8'hFF;
        i_liems_host_model.eoi_both();
        i_liems_host_model.sel(1'b1, 1'b0);
        chk(32'(host_rdata), 32'h0);
        chk(32'(intr), 32'h0);
    endtask
    task automatic t_mask();
        i_liems_host_model.cmd(1'b0, 1'b1, 8'h04);
        ext_n[0] <= 1'b0;
        wt(3);
        chk(32'(intr), 32'h0);
        i_liems_host_model.sel(1'b0, 1'b1);
        chk(32'(host_rdata), 32'h04);
        i_liems_host_model.cmd(1'b0, 1'b1, 8'h00);
        wt(2);
        chk(32'(intr), 32'h1);
        cfg_write(8'h60, 4'h1, 32'h00000088);
        wt(2);
        chk(32'(intr), 32'h0);
        cfg_write(8'h60, 4'h1, 32'h00000008);
        wt(2);
        chk(32'(intr), 32'h0);
        ext_n <= 8'hEF;
        cfg_write(8'h68, 4'h1, 32'h0000000E);
        wt(2);
        i_liems_host_model.ack();
        chk(32'(ack_level), 32'hE);
        ext_n <= 8'hFF;
        i_liems_host_model.eoi_both();
        cfg_write(8'h60, 4'hF, 32'h80808080);
        cfg_write(8'h68, 4'hF, 32'h80808080);
    endtask
    task automatic t_nest();
        legacy[5] <= 1'b1;
        wt(2);
        i_liems_host_model.ack();
        chk(32'(ack_level), 32'h5);
        legacy <= 16'h0040;
        wt(3);
        chk(32'(intr), 32'h0);
        legacy <= 16'h0048;
        wt(3);
        chk(32'(intr), 32'h1);
        i_liems_host_model.ack();
        chk(32'(ack_level), 32'h3);
        legacy[3] <= 1'b0;
        i_liems_host_model.sel(1'b0, 1'b0);
        chk(32'(host_rdata), 32'h28);
        i_liems_host_model.cmd(1'b0, 1'b0, 8'h20);
        i_liems_host_model.sel(1'b0, 1'b0);
        chk(32'(host_rdata), 32'h20);
    endtask
    task automatic t_smm();
        i_liems_host_model.cmd(1'b0, 1'b1, 8'h20);
        i_liems_host_model.cmd(1'b0, 1'b0, 8'h68);
        wt(3);
        chk(32'(intr), 32'h1);
        i_liems_host_model.ack();
        chk(32'(ack_level), 32'h6);
        legacy[6] <= 1'b0;
        i_liems_host_model.cmd(1'b0, 1'b0, 8'h20);
        i_liems_host_model.sel(1'b0, 1'b0);
        chk(32'(host_rdata), 32'h20);
        i_liems_host_model.cmd(1'b0, 1'b0, 8'h48);
        i_liems_host_model.cmd(1'b0, 1'b0, 8'h65);
        i_liems_host_model.sel(1'b0, 1'b0);
        chk(32'(host_rdata), 32'h00);
        i_liems_host_model.cmd(1'b0, 1'b1, 8'h00);
    endtask
    task automatic t_auto_edge();
        auto_completion_mode <= 1'b1;
        legacy[4] <= 1'b1;
        wt(2);
        i_liems_host_model.ack();
        legacy[4] <= 1'b0;
        chk(32'(ack_level), 32'h4);
        i_liems_host_model.sel(1'b0, 1'b0);
        chk(32'(host_rdata), 32'h00);
        auto_completion_mode <= 1'b0;
        edge_level_select[3] <= 1'b0;
        legacy[3] <= 1'b1;
        wt(3);
        i_liems_host_model.ack();
        chk(32'(ack_level), 32'h3);
        i_liems_host_model.cmd(1'b0, 1'b0, 8'h20);
        wt(3);
        chk(32'(intr), 32'h0);
        legacy[3] <= 1'b0;
        edge_level_select[3] <= 1'b1;
    endtask
    task automatic t_internal();
        pm <= 1'b1;
        wt(3);
        chk(32'(pci_oe), 32'h01);
        pm <= 1'b0;
        health <= 1'b1;
        wt(3);
        chk(32'(pci_oe), 32'h08);
        health <= 1'b0;
        wt(3);
        chk(32'(pci_oe), 32'h00);
        cfg_write(8'h60, 4'h1, 32'h00000003);
        legacy[3] <= 1'b1;
        wt(2);
        chk(32'(intr), 32'h0);
        pm <= 1'b1;
        wt(3);
        chk(32'(intr), 32'h1);
        chk(32'(pci_o), 32'h00);
        pm <= 1'b0;
        legacy[3] <= 1'b0;
        wt(3);
        chk(32'(intr), 32'h0);
    endtask
    always @(posedge clk_sys_i)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            $display("Error %0t: run did not finish in time", $time);
            fail_count++;
            summarize();
        end
    end
    initial
    begin
        repeat (5) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        t_reset();
        t_steer();
        t_mask();
        t_nest();
        t_smm();
        t_auto_edge();
        t_internal();
        summarize();
    end
endmodule

// *** tb/liems_host_model.sv ***
// host processor model: command byte writes, register select and acknowledge pulses
module liems_host_model (
    input  wire logic       clk_sys_i,
    output      logic       host_wr_o,
    output      logic       host_sec_o,
    output      logic       host_a0_o,
    output      logic [7:0] host_wdata_o,
    output      logic       ack_n_o
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        host_wr_o = 1'b0;
        host_sec_o = 1'b0;
        host_a0_o = 1'b0;
        host_wdata_o = 8'h00;
        ack_n_o = 1'b1;
    end
    task automatic cmd(input logic sec, input logic a0, input logic [7:0] d);
        @(posedge clk_sys_i);
        host_wr_o <= 1'b1;
        host_sec_o <= sec;
        host_a0_o <= a0;
        host_wdata_o <= d;
        @(posedge clk_sys_i);
        host_wr_o <= 1'b0;
        host_wdata_o <= ~d;
    endtask
    // secondary first, then primary
    task automatic eoi_both();
        cmd(1'b1, 1'b0, 8'h20);
        cmd(1'b0, 1'b0, 8'h20);
    endtask
    // select a readback register; returns once the data has settled
    task automatic sel(input logic sec, input logic a0);
        @(posedge clk_sys_i);
        host_sec_o <= sec;
        host_a0_o <= a0;
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask
    // two low pulses; auto completion is only ever enabled on the primary side
    task automatic ack();
        repeat (2)
        begin
            @(posedge clk_sys_i);
            ack_n_o <= 1'b0;
            @(posedge clk_sys_i);
            ack_n_o <= 1'b1;
        end
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask
endmodule
